/* File: design/fpw_pkg.sv */
// Purpose: Shared constants for the flash power-up write-inhibit block.
// Assumes: System clock of 25 MHz.
// Notes: Times are kept in their own unit; cycle counts are derived from them.
package fpw_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // Write-inhibit delay window in microseconds: 1 ms least, 10 ms most
    localparam int unsigned WR_INH_MIN_US = 1000;
    localparam int unsigned WR_INH_MAX_US = 10000;
    // Chosen delay sits at the least legal value in whole cycles, never below one
    localparam int unsigned WR_INH_CYC =
        (WR_INH_MIN_US * (CLK_HZ / 1000000) + 0) > 0 ?
        WR_INH_MIN_US * (CLK_HZ / 1000000) : 1;
    // Select-after-supply delay, 30 us least
    localparam int unsigned SEL_DLY_US = 30;
    localparam int unsigned SEL_DLY_CYC = SEL_DLY_US * (CLK_HZ / 1000000);
    localparam int CNT_W = 18;
    // Instruction opcode width and erased content
    localparam int OP_W = 8;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Instruction classes presented by the command decoder
    typedef enum logic [2:0] {
        FPW_CMD_NONE = 3'h0,
        FPW_CMD_READ = 3'h1,
        FPW_CMD_WRITE_ENABLE = 3'h2,
        FPW_CMD_WRITE_TYPE = 3'h3,
        FPW_CMD_WRITE_DISABLE = 3'h4,
        FPW_CMD_DEEP_DOWN = 3'h5,
        FPW_CMD_RELEASE = 3'h6,
        FPW_CMD_OTHER = 3'h7
    } fpw_cmd_t;
    // Power phase, Gray coded along off -> select wait -> read ok -> write ok
    typedef enum logic [1:0] {
        FPW_OFF = 2'b00,
        FPW_SEL_WAIT = 2'b01,
        FPW_READ_OK = 2'b11,
        FPW_WRITE_OK = 2'b10
    } fpw_phase_t;
endpackage

/* File: design/fpw_timer.sv */
// Purpose: Write-inhibit delay counter with terminal-count permit flag.
// Assumes: i_run comes from a synchronised supply-good level.
// Notes: Dropping i_run clears count and flag at once.
`timescale 1ns/1ps
module fpw_timer #(
    parameter int unsigned COUNT = fpw_pkg::WR_INH_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_run,
    output logic o_done
);
    typedef struct packed {
        logic [fpw_pkg::CNT_W-1:0] cnt;
        logic done;
    } fpw_tmr_st_t;
    fpw_tmr_st_t st_q;
    fpw_tmr_st_t st_d;
    localparam logic [fpw_pkg::CNT_W-1:0] LAST = fpw_pkg::CNT_W'(COUNT - 1);

    // Count from supply-good, latch flag at terminal count
    always_comb begin
        st_d = st_q;
        if (!i_run) begin
            st_d.cnt = '0;
            st_d.done = 1'b0;
        end else if (!st_q.done) begin
            if (st_q.cnt == LAST) begin
                st_d.done = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_done = st_q.done;
endmodule

/* File: design/fpw_gate.sv */
// Purpose: Power-up sequencing and instruction gating for a serial flash.
// Assumes: Command decoder presents one classified instruction per pulse.
// Notes: Supply-good and reset pins are synchronised before use.
// Notes: Both delays restart in full on any loss of power or reset pin assertion.
// Notes: Write-type covers page write, page program, page erase and sector erase.
// Notes: Dropping power mid-write can leave data half written; that risk is the host's.
// Notes: Every output is a field of the registered state.
// Notes on behaviour
// - Below the inhibit threshold all logic is held in reset and no instruction is answered.
// - Write-enable and write-type instructions are dropped until the inhibit delay passes.
// - Reads are accepted once the select delay has run, even during the inhibit delay.
// - Power-up lands in standby, never deep power-down.
// - Power-up clears the write-enable latch.
// - Supply falling below the threshold disables everything and silences the device.
// - Delivered state is an erased array of all ones and status bits of zero.
`timescale 1ns/1ps
module fpw_gate #(
    parameter int unsigned WR_INH_CYC = fpw_pkg::WR_INH_CYC,
    parameter int unsigned SEL_DLY_CYC = fpw_pkg::SEL_DLY_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_supply_good,
    input wire logic i_pin_reset_n,
    input wire logic i_cmd_valid,
    input wire fpw_pkg::fpw_cmd_t i_cmd,
    input wire logic i_write_done,
    output logic o_cmd_accept,
    output logic o_cmd_reject,
    output logic o_logic_active,
    output logic o_read_allowed,
    output logic o_write_allowed,
    output logic o_write_enable_latch,
    output logic o_deep_power_down,
    output logic [7:0] o_status,
    output logic [7:0] o_erased_fill
);
    typedef struct packed {
        logic [1:0] sup_sync;
        logic [1:0] rst_sync;
        fpw_pkg::fpw_phase_t phase;
        logic [fpw_pkg::CNT_W-1:0] sel_cnt;
        logic write_enable_latch;
        logic deep;
        logic accept;
        logic reject;
        logic rd_ok;
        logic wr_ok;
        // Registered copies so every output comes from a flop
        logic act;
        logic [7:0] status;
        logic [7:0] fill;
    } fpw_st_t;
    fpw_st_t st_q;
    fpw_st_t st_d;
    logic wr_permit;
    logic powered;
    // Last value of the select counter; worked out once here
    // rather than in the phase case, so widths are settled in one place
    localparam logic [fpw_pkg::CNT_W-1:0] SEL_LAST = fpw_pkg::CNT_W'(SEL_DLY_CYC - 1);

    // Powered only while supply is good and the reset pin is released
    assign powered = st_q.sup_sync[1] & st_q.rst_sync[1];

    // Timer sees the same synchronised power as the phase logic
    fpw_timer #(
        .COUNT(WR_INH_CYC)
    ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_run(powered),
        .o_done(wr_permit)
    );

    // Is this class a write-type that the inhibit delay blocks
    function automatic logic is_write_class(input fpw_pkg::fpw_cmd_t c);
        return (c == fpw_pkg::FPW_CMD_WRITE_ENABLE) || (c == fpw_pkg::FPW_CMD_WRITE_TYPE);
    endfunction

    // Phases in which reads are served
    function automatic logic phase_reads_ok(input fpw_pkg::fpw_phase_t p);
        return (p == fpw_pkg::FPW_READ_OK) || (p == fpw_pkg::FPW_WRITE_OK);
    endfunction

    // Phase that raises write-allowed; the inhibit gate itself reads the timer flag
    function automatic logic phase_writes_ok(input fpw_pkg::fpw_phase_t p);
        return p == fpw_pkg::FPW_WRITE_OK;
    endfunction

    // Power-up timeline, counted in clock edges after supply-good and the reset pin
    // are both high at the pins:
    //   edges 1-2    the two synchroniser stages fill, nothing is answered yet
    //   edge 3       phase leaves off; every instruction is refused with a pulse
    //   +SEL_DLY_CYC reads become legal and stay legal until power is lost
    //   timer done   write-enable and write-type classes pass the inhibit gate
    // The host is expected to wait out both delays itself; the local counters
    // only make sure that a hasty host cannot corrupt the array.
    // A falling supply takes two edges to reach the logic; the host must have
    // deselected long before then, so no instruction is in flight.

    // Phase sequencing and instruction gating
    always_comb begin
        st_d = st_q;
        // Two-flop synchronisers; only the second stage is read by logic
        st_d.sup_sync = {st_q.sup_sync[0], i_supply_good};
        st_d.rst_sync = {st_q.rst_sync[0], i_pin_reset_n};
        st_d.accept = 1'b0;
        st_d.reject = 1'b0;
        if (!powered) begin
            // Whole state drops back to power-up values; nothing answers.
            // A brief dip restarts both delays in full, trading a slower
            // recovery for never trusting a half-settled supply.
            st_d.phase = fpw_pkg::FPW_OFF;
            st_d.sel_cnt = '0;
            st_d.write_enable_latch = 1'b0;
            st_d.deep = 1'b0;
        end else begin
            // Advance the power phase
            case (st_q.phase)
                fpw_pkg::FPW_OFF: begin
                    st_d.phase = fpw_pkg::FPW_SEL_WAIT;
                end
                fpw_pkg::FPW_SEL_WAIT: begin
                    // Select delay counted locally; host should also wait it out
                    if (st_q.sel_cnt == SEL_LAST) begin
                        st_d.phase = fpw_pkg::FPW_READ_OK;
                    end else begin
                        st_d.sel_cnt = st_q.sel_cnt + 1'b1;
                    end
                end
                fpw_pkg::FPW_READ_OK: begin
                    if (wr_permit) begin
                        st_d.phase = fpw_pkg::FPW_WRITE_OK;
                    end
                end
                fpw_pkg::FPW_WRITE_OK: begin
                    // Held until the supply or the reset pin is lost
                    st_d.phase = fpw_pkg::FPW_WRITE_OK;
                end
                default: begin
                    st_d.phase = fpw_pkg::FPW_OFF;
                end
            endcase
            // Completion of a write cycle drops the latch
            if (i_write_done) begin
                st_d.write_enable_latch = 1'b0;
            end
            // Instruction gating; accept and reject are one-cycle pulses
            if (i_cmd_valid) begin
                if (!phase_reads_ok(st_q.phase)) begin
                    // Select delay still running: nothing is taken yet
                    st_d.reject = 1'b1;
                end else if (st_q.deep) begin
                    // Deep power-down listens only for release
                    if (i_cmd == fpw_pkg::FPW_CMD_RELEASE) begin
                        st_d.deep = 1'b0;
                        st_d.accept = 1'b1;
                    end else begin
                        st_d.reject = 1'b1;
                    end
                end else if (is_write_class(i_cmd) && !wr_permit) begin
                    // Inhibit delay not yet over
                    st_d.reject = 1'b1;
                end else if (i_cmd == fpw_pkg::FPW_CMD_WRITE_TYPE && !st_q.write_enable_latch) begin
                    // A write-type needs a fresh write-enable first
                    st_d.reject = 1'b1;
                end else begin
                    st_d.accept = 1'b1;
                    // Placed after the write-done clear, so a new enable wins
                    case (i_cmd)
                        fpw_pkg::FPW_CMD_WRITE_ENABLE: begin
                            st_d.write_enable_latch = 1'b1;
                        end
                        fpw_pkg::FPW_CMD_WRITE_DISABLE: begin
                            st_d.write_enable_latch = 1'b0;
                        end
                        fpw_pkg::FPW_CMD_DEEP_DOWN: begin
                            st_d.deep = 1'b1;
                        end
                        default: begin
                            // Reads and the rest change no local state
                        end
                    endcase
                end
            end
        end
        // Output levels follow the next phase so they move with it
        st_d.act = st_d.phase != fpw_pkg::FPW_OFF;
        st_d.rd_ok = powered && phase_reads_ok(st_d.phase);
        st_d.wr_ok = powered && phase_writes_ok(st_d.phase);
        // Status reads zero except the latch in bit 1; fill shows the erased byte
        st_d.status = fpw_pkg::STATUS_RESET | {6'h00, st_d.write_enable_latch, 1'b0};
        st_d.fill = fpw_pkg::ERASED_BYTE;
    end

    // Async reset gives constants only; the pin levels arrive via the synchronisers
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '{sup_sync: 2'b00, rst_sync: 2'b00, phase: fpw_pkg::FPW_OFF,
                      status: fpw_pkg::STATUS_RESET, fill: fpw_pkg::ERASED_BYTE,
                      default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs are plain fields of the registered state,
    // so none of them carries a decode glitch to the pins
    assign o_cmd_accept = st_q.accept;
    assign o_cmd_reject = st_q.reject;
    assign o_logic_active = st_q.act;
    assign o_status = st_q.status;
    assign o_erased_fill = st_q.fill;
    assign o_read_allowed = st_q.rd_ok;
    assign o_write_allowed = st_q.wr_ok;
    assign o_write_enable_latch = st_q.write_enable_latch;
    assign o_deep_power_down = st_q.deep;
endmodule

/* File: bench/fpw_gate_properties.sv */
// Purpose: Port assertions for the write-inhibit gate
// Assumes: One clock, async active-low reset
// Notes: up_q counts raw powered cycles, ahead of the synchronisers
`timescale 1ns/1ps
module fpw_gate_props #(
    parameter int unsigned WR_INH_CYC = fpw_pkg::WR_INH_CYC,
    parameter int unsigned SEL_DLY_CYC = fpw_pkg::SEL_DLY_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_supply_good,
    input wire logic i_pin_reset_n,
    input wire logic i_cmd_valid,
    input wire fpw_pkg::fpw_cmd_t i_cmd,
    input wire logic o_cmd_accept,
    input wire logic o_cmd_reject,
    input wire logic o_logic_active,
    input wire logic o_read_allowed,
    input wire logic o_write_allowed,
    input wire logic o_write_enable_latch,
    input wire logic o_deep_power_down,
    input wire logic [7:0] o_status,
    input wire logic [7:0] o_erased_fill
);
    int unsigned up_q;
    // Any loss restarts the count, as it must restart the inhibit wait
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) up_q <= 0;
        else up_q <= (i_supply_good && i_pin_reset_n) ? up_q + 1 : 0;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    property p_off; (!i_supply_good)[*5] |-> !(o_logic_active || o_cmd_accept || o_cmd_reject);
    endproperty
    a_off: assert property (p_off) else $error("answer while unpowered");
    property p_up; $rose(o_logic_active) |-> !(o_deep_power_down || o_write_enable_latch);
    endproperty
    a_up: assert property (p_up) else $error("bad power-up state");
    property p_wel; $rose(o_write_enable_latch) |-> o_cmd_accept &&
        $past(i_cmd) == fpw_pkg::FPW_CMD_WRITE_ENABLE; endproperty
    a_wel: assert property (p_wel) else $error("latch set without command");
    property p_gate; o_cmd_accept && $past(i_cmd) inside {fpw_pkg::FPW_CMD_WRITE_ENABLE,
        fpw_pkg::FPW_CMD_WRITE_TYPE} |-> o_write_allowed; endproperty
    a_gate: assert property (p_gate) else $error("write taken while inhibited");
    property p_early; o_write_allowed && i_supply_good && i_pin_reset_n |-> up_q >= WR_INH_CYC;
    endproperty
    a_early: assert property (p_early) else $error("write permit too early");
    property p_late; up_q > WR_INH_CYC + 8 |-> o_write_allowed; endproperty
    a_late: assert property (p_late) else $error("write permit too late");
    property p_rd; i_cmd_valid && i_cmd == fpw_pkg::FPW_CMD_READ && o_read_allowed &&
        !o_deep_power_down |=> o_cmd_accept; endproperty
    a_rd: assert property (p_rd) else $error("read refused");
    property p_stat; o_status == {6'h00, o_write_enable_latch, 1'h0}; endproperty
    a_stat: assert property (p_stat) else $error("status bits wrong");
    property p_fill; o_erased_fill == 8'hff; endproperty
    a_fill: assert property (p_fill) else $error("erased fill wrong");
    property p_sel; o_read_allowed && i_supply_good && i_pin_reset_n |-> up_q >= SEL_DLY_CYC;
    endproperty
    a_sel: assert property (p_sel) else $error("reads opened too early");
    property p_sel_late; up_q > SEL_DLY_CYC + 8 |-> o_read_allowed; endproperty
    a_sel_late: assert property (p_sel_late) else $error("reads opened too late");
    c_wel: cover property (o_write_enable_latch && o_cmd_accept);
    c_dpd: cover property ($rose(o_deep_power_down));
    c_rd: cover property (o_cmd_accept && !o_write_allowed);
endmodule
bind fpw_gate fpw_gate_props #(.WR_INH_CYC(WR_INH_CYC), .SEL_DLY_CYC(SEL_DLY_CYC)) i_props (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_supply_good(i_supply_good),
    .i_pin_reset_n(i_pin_reset_n),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd),
    .o_cmd_accept(o_cmd_accept),
    .o_cmd_reject(o_cmd_reject),
    .o_logic_active(o_logic_active),
    .o_read_allowed(o_read_allowed),
    .o_write_allowed(o_write_allowed),
    .o_write_enable_latch(o_write_enable_latch),
    .o_deep_power_down(o_deep_power_down),
    .o_status(o_status),
    .o_erased_fill(o_erased_fill)
);

/* File: bench/fpw_host_model.sv */
// Purpose: Host side: supply, reset pin and classified instructions
// Assumes: One instruction per pulse
// Notes: Drives on falling edges; a released class bus shows the inverse
`timescale 1ns/1ps
module fpw_host_model #(parameter int SEL_CYC = 5) (
    input wire logic i_sys_clk,
    output logic o_supply_good = 1'b0,
    output logic o_pin_reset_n = 1'b0,
    output logic o_cmd_valid = 1'b0,
    output fpw_pkg::fpw_cmd_t o_cmd = fpw_pkg::FPW_CMD_NONE
);
    // Reset pin low around every supply edge as extra protection
    task automatic power(input logic on, input logic settle);
        @(negedge i_sys_clk);
        o_pin_reset_n = 1'b0;
        o_supply_good = on;
        @(negedge i_sys_clk);
        o_pin_reset_n = on;
        // Deselected for SEL_CYC + 4 cycles, past the select delay only, not the inhibit delay
        if (settle) repeat (SEL_CYC + 4) @(negedge i_sys_clk);
    endtask
    task automatic send(input logic [2:0] c);
        @(negedge i_sys_clk);
        o_cmd_valid = 1'b1;
        o_cmd = fpw_pkg::fpw_cmd_t'(c);
        @(negedge i_sys_clk);
        o_cmd_valid = 1'b0;
        o_cmd = fpw_pkg::fpw_cmd_t'(~c);
    endtask
endmodule

/* File: bench/testbench.sv */
// Purpose: Self-checking bench for the write-inhibit gate
// Assumes: Delays shortened to 20 and 5 cycles
// Notes: Class codes 1 read, 2 write-enable, 3 write-type, 4 disable, 5 deep, 6 release
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wdone = 1'b0;
    logic sup, pin_n, vld, acc, rej, act, rd, wr, write_enable_latch, dpd;
    logic [7:0] st, fill;
    fpw_pkg::fpw_cmd_t cmd;
    int miscompares = 0;
    int n_compared = 0;
    always #20 clk = ~clk;
    fpw_gate #(.WR_INH_CYC(20), .SEL_DLY_CYC(5)) i_dut (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_supply_good(sup), .i_pin_reset_n(pin_n), .i_cmd_valid(vld), .i_cmd(cmd),
        .i_write_done(wdone), .o_cmd_accept(acc), .o_cmd_reject(rej), .o_logic_active(act),
        .o_read_allowed(rd), .o_write_allowed(wr), .o_write_enable_latch(write_enable_latch),
        .o_deep_power_down(dpd), .o_status(st), .o_erased_fill(fill));
    fpw_host_model #(.SEL_CYC(5)) i_host (.i_sys_clk(clk), .o_supply_good(sup),
        .o_pin_reset_n(pin_n), .o_cmd_valid(vld), .o_cmd(cmd));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // The answer stands for the one cycle after the taking edge; judge it inside that cycle
    task automatic issue(input logic [2:0] c, input logic [1:0] exp);
        i_host.send(c);
        chk({6'h00, acc, rej}, {6'h00, exp});
    endtask
    // Bounded wait on write (w=1) or read permission
    task automatic wait_lvl(input logic w);
        for (int i = 0; i < 100 && (w ? wr : rd) !== 1'b1; i++) @(negedge clk);
        chk({7'h00, w ? wr : rd}, 8'h01);
    endtask
    task automatic t_up();
        issue(3'h1, 2'b00);
        i_host.power(1'b1, 1'b0);
        repeat (3) @(negedge clk);
        issue(3'h1, 2'b01);
        chk({5'h00, dpd, write_enable_latch, wr}, 8'h00);
        chk(st, 8'h00);
        wait_lvl(1'b0);
        issue(3'h1, 2'b10);
        issue(3'h2, 2'b01);
        issue(3'h3, 2'b01);
        chk({7'h00, wr}, 8'h00);
    endtask
    // Write flow, then every class in deep power-down; release (6) leaves it and deep (5) re-enters it
    task automatic t_wr();
        wait_lvl(1'b1);
        issue(3'h3, 2'b01);
        issue(3'h2, 2'b10);
        chk(st, 8'h02);
        issue(3'h3, 2'b10);
        @(negedge clk) wdone = 1'b1;
        @(negedge clk) wdone = 1'b0;
        chk({7'h00, write_enable_latch}, 8'h00);
        issue(3'h2, 2'b10);
        chk({7'h00, write_enable_latch}, 8'h01);
        issue(3'h4, 2'b10);
        chk({7'h00, write_enable_latch}, 8'h00);
        issue(3'h3, 2'b01);
        issue(3'h2, 2'b10);
        issue(3'h5, 2'b10);
        for (int k = 7; k >= 0; k--) issue(k[2:0], (k == 6 || k == 5) ? 2'b10 : 2'b01);
    endtask
    // Supply loss in deep power-down with the latch set, then power-up again
    task automatic t_down();
        i_host.power(1'b0, 1'b0);
        repeat (5) @(negedge clk);
        chk({5'h00, act, rd, wr}, 8'h00);
        issue(3'h6, 2'b00);
        i_host.power(1'b1, 1'b1);
        wait_lvl(1'b0);
        chk({5'h00, dpd, write_enable_latch, wr}, 8'h00);
    endtask
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Run is under a hundred cycles; a hang is cut short well past that
    initial begin
        #100000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (6) @(negedge clk);
        chk({6'h00, act, acc}, 8'h00);
        chk(fill, 8'hff);
        rst_n = 1'b1;
        t_up();
        t_wr();
        t_down();
        test_done();
    end
endmodule
